// >>> bench/pin_change_properties.sv
// checker on the ports of the pin change detector
// assumes zero wait states and pins quiet low during reset
`timescale 1ns/1ps
`include "pin_change_params.svh"
module pin_change_properties (
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire pin_change_pkg::ahb_req_s ahbReq,
   input wire logic [31:0] hwdata,
   input wire pin_change_pkg::ahb_resp_s ahbResp,
   input wire logic [7:0] secondPortPin,
   input wire logic [7:0] thirdPortPin,
   input wire logic summaryChangeFlag,
   input wire logic irqOut
);
   import pin_change_pkg::*;
   // ----
   // properties
   // ----
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!rst_n);
   wire logic rdAny = ahbReq.hsel && ahbReq.hready && ahbReq.htrans[1] && !ahbReq.hwrite;
   wire logic wrAny = ahbReq.hsel && ahbReq.hready && ahbReq.htrans[1] && ahbReq.hwrite;
   wire logic rdB = rdAny && ahbReq.haddr[11:0] <= 12'h008;
   wire logic rdF = rdAny && (ahbReq.haddr[11:0] == 12'h008 || ahbReq.haddr[11:0] == 12'h010);
   sequence s_take(logic [11:0] a);
      rdAny && ahbReq.haddr[11:0] == a;
   endsequence
   property p_reset_clear;
      $rose(rst_n) |-> !summaryChangeFlag && !irqOut;
   endproperty
   a_reset_clear: assert property (p_reset_clear) else $error("outputs set after reset");
   property p_pin_cause;
      $rose(summaryChangeFlag) |-> $past(secondPortPin[7:4], 4) != $past(secondPortPin[7:4], 3)
         || $past(thirdPortPin, 4) != $past(thirdPortPin, 3);
   endproperty
   a_pin_cause: assert property (p_pin_cause) else $error("summary without pin edge");
   property p_hold;
      $fell(summaryChangeFlag) |-> $past(wrAny) || $past(wrAny, 2);
   endproperty
   a_hold: assert property (p_hold) else $error("summary dropped without write");
   property p_low_zero;
      rdB |=> ahbResp.hrdata[3:0] == 4'h0;
   endproperty
   a_low_zero: assert property (p_low_zero) else $error("low nibble not zero");
   property p_ctl_summary;
      s_take(`OFS_CONTROL) |=> ahbResp.hrdata[1] == $past(summaryChangeFlag);
   endproperty
   a_ctl_summary: assert property (p_ctl_summary) else $error("summary bit mismatch");
   property p_flag_or;
      rdF |=> (|ahbResp.hrdata[7:0]) -> summaryChangeFlag;
   endproperty
   a_flag_or: assert property (p_flag_or) else $error("flag set, summary low");
   property p_okay;
      ahbResp.hreadyout && !ahbResp.hresp;
   endproperty
   a_okay: assert property (p_okay) else $error("bus not ready or error");
   property p_stand;
      !rdAny |=> $stable(ahbResp.hrdata);
   endproperty
   a_stand: assert property (p_stand) else $error("read data moved");
endmodule
bind pin_edge_change_detect pin_change_properties u_pin_change_properties (
   .ref_clk(ref_clk), .rst_n(rst_n), .ahbReq(ahbReq), .hwdata(hwdata), .ahbResp(ahbResp),
   .secondPortPin(secondPortPin), .thirdPortPin(thirdPortPin),
   .summaryChangeFlag(summaryChangeFlag), .irqOut(irqOut));

// >>> bench/pin_drive_model.sv
// partner: outside circuits that drive the port pins
// assumes the bench sets wanted levels at clock edges
`timescale 1ns/1ps
module pin_drive_model (
   input wire logic [7:0] bWant,
   input wire logic [7:0] cWant,
   output logic [7:0] bPin,
   output logic [7:0] cPin
);
   // ----
   // pins
   // ----
   // skewed so edges land between clock edges, as real pins do
   assign #3 bPin = bWant;
   assign #3 cPin = cWant;
endmodule

// >>> bench/pin_edge_change_detect_tb.sv
// self-checking bench for the pin change detector
// assumes the full variant and a single bus master
`timescale 1ns/1ps
`include "pin_change_params.svh"
module pin_edge_change_detect_tb;
   import pin_change_pkg::*;
   logic ref_clk = 0, rst_n = 0, wr = 0, sel = 0;
   logic [1:0] trans = TRANS_IDLE;
   logic [11:0] addr = 0;
   logic [31:0] hwdata = 0, rd;
   logic [7:0] bWant = 0, cWant = 0, bPin, cPin, rb, rf, cr, nb, nc, bF, cF;
   ahb_req_s ahbReq;
   ahb_resp_s ahbResp;
   logic summaryChangeFlag, irqOut;
   int errors = 0, check_count = 0, cycles = 0, i;
   assign ahbReq = '{htrans: trans, haddr: {20'h0, addr}, hwrite: wr, hsize: 3'h2,
      hsel: sel, hready: ahbResp.hreadyout};
   pin_edge_change_detect u_pin_edge_change_detect (.ref_clk(ref_clk), .rst_n(rst_n),
      .ahbReq(ahbReq), .hwdata(hwdata), .ahbResp(ahbResp), .secondPortPin(bPin),
      .thirdPortPin(cPin), .summaryChangeFlag(summaryChangeFlag), .irqOut(irqOut));
   pin_drive_model u_pin_drive_model (.bWant(bWant), .cWant(cWant), .bPin(bPin), .cPin(cPin));
   // ----
   // helpers
   // ----
   always #5 ref_clk = ~ref_clk;
   task report_and_stop;
      if (errors == 0 && check_count > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   // a hang ends the run as a failure
   always @(posedge ref_clk) begin
      cycles++;
      if (cycles > 5000) begin
         errors++;
         report_and_stop();
      end
   end
   task check(input string n, input logic [31:0] s, input logic [31:0] e);
      check_count++;
      if (s !== e) begin
         errors++;
         $display("ERROR %s expected %h seen %h", n, e, s);
      end
   endtask
   task bus(input logic w, input logic [11:0] a, input logic [31:0] d);
      trans <= TRANS_NONSEQ;
      addr <= a;
      wr <= w;
      sel <= 1'b1;
      do @(posedge ref_clk); while (ahbResp.hreadyout !== 1'b1);
      trans <= TRANS_IDLE;
      sel <= 1'b0;
      hwdata <= d;
      do @(posedge ref_clk); while (ahbResp.hreadyout !== 1'b1);
      rd = ahbResp.hrdata;
   endtask
   task rdchk(input string n, input logic [11:0] a, input logic [31:0] e);
      bus(1'b0, a, 32'h0);
      check(n, rd, e);
   endtask
   function logic [7:0] edges(input logic [7:0] o, n, r, f);
      return (r & ~o & n) | (f & o & ~n);
   endfunction
   // ----
   // tests
   // ----
   initial begin
      void'($urandom(32'h5E2B2037));
      repeat (5) @(posedge ref_clk);
      rst_n <= 1'b1;
      @(posedge ref_clk);
      for (i = 0; i < 9; i++) rdchk("reset", 12'(i * 4), 32'h0);
      bus(1'b1, `OFS_PORTB_RISE_ENABLE, '1);
      rdchk("rise_b", `OFS_PORTB_RISE_ENABLE, 32'hF0);
      bus(1'b1, `OFS_PORTB_FALL_ENABLE, '1);
      rdchk("fall_b", `OFS_PORTB_FALL_ENABLE, 32'hF0);
      bus(1'b1, `OFS_PORTB_CHANGE_FLAGS, '1);
      rdchk("flag_w", `OFS_PORTB_CHANGE_FLAGS, 32'h0);
      bus(1'b1, `OFS_PORTC_RISE_ENABLE, '1);
      rdchk("rise_c", `OFS_PORTC_RISE_ENABLE, 32'hFF);
      bus(1'b1, `OFS_IRQ_MASK, 32'h3);
      for (i = 0; i < 24; i++) begin
         rb = (i == 0) ? 8'h0 : 8'($urandom) & `PORTB_IMPL_MASK;
         rf = (i == 0) ? 8'h0 : 8'($urandom) & `PORTB_IMPL_MASK;
         cr = 8'($urandom);
         nb = 8'($urandom);
         nc = 8'($urandom);
         bus(1'b1, `OFS_CONTROL, {31'h0, i[0]});
         bus(1'b1, `OFS_PORTB_RISE_ENABLE, {24'h0, rb});
         bus(1'b1, `OFS_PORTB_FALL_ENABLE, {24'h0, rf});
         bus(1'b1, `OFS_PORTC_RISE_ENABLE, {24'h0, cr});
         bF = edges(bWant, nb, rb, rf) & `PORTB_IMPL_MASK;
         cF = edges(cWant, nc, cr, 8'h0);
         bWant <= nb;
         cWant <= nc;
         // two edges through the synchroniser, one to set the flag, one more to settle
         repeat (4) @(posedge ref_clk);
         rdchk("flag_b", `OFS_PORTB_CHANGE_FLAGS, {24'h0, bF});
         rdchk("flag_c", `OFS_PORTC_CHANGE_FLAGS, {24'h0, cF});
         rdchk("ctl", `OFS_CONTROL, {30'h0, |{bF, cF}, i[0]});
         rdchk("status", `OFS_IRQ_STATUS, {30'h0, |cF, |bF});
         check("irq", irqOut, i[0] & |{bF, cF});
         bus(1'b1, `OFS_PORTB_CHANGE_FLAGS, 32'h0);
         bus(1'b1, `OFS_PORTC_CHANGE_FLAGS, 32'h0);
         bus(1'b1, `OFS_IRQ_STATUS, 32'h3);
         check("cleared", summaryChangeFlag, 1'b0);
      end
      rst_n <= 1'b0;
      repeat (2) @(posedge ref_clk);
      rst_n <= 1'b1;
      @(posedge ref_clk);
      rdchk("rereset", `OFS_PORTC_RISE_ENABLE, 32'h0);
      report_and_stop();
   end
endmodule

// >>> design/pin_change_params.svh
// offsets, field positions, reset values and timing counts for the pin change detector
// assumes a 32-bit AHB-Lite slave with word-aligned registers
`ifndef PIN_CHANGE_PARAMS_SVH
`define PIN_CHANGE_PARAMS_SVH

`define OFS_PORTB_RISE_ENABLE 12'h000
`define OFS_PORTB_FALL_ENABLE 12'h004
`define OFS_PORTB_CHANGE_FLAGS 12'h008
`define OFS_PORTC_RISE_ENABLE 12'h00C
`define OFS_PORTC_CHANGE_FLAGS 12'h010
`define OFS_CONTROL 12'h014
`define OFS_IRQ_STATUS 12'h018
`define OFS_IRQ_MASK 12'h01C

`define PORTB_IMPL_MASK 8'hF0
`define PORTC_FULL_MASK 8'hFF
`define PORTC_SMALL_MASK 8'h3F
`define REG_RESET 8'h00
`define CTRL_MASTER_EN_BIT 0
`define STAT_PORTB_BIT 0
`define STAT_PORTC_BIT 1
`define STAT_MASK 2'h3
`define SYNC_STAGES 2

`endif

// >>> design/pin_change_pkg.sv
// types shared by the pin change detector
// assumes the params header is compiled alongside
package pin_change_pkg;

   typedef struct packed {
      logic [1:0] htrans;
      logic [31:0] haddr;
      logic hwrite;
      logic [2:0] hsize;
      logic hsel;
      logic hready;
   } ahb_req_s;

   typedef struct packed {
      logic [31:0] hrdata;
      logic hreadyout;
      logic hresp;
   } ahb_resp_s;

   typedef enum logic [1:0] {
      TRANS_IDLE = 2'h0,
      TRANS_BUSY = 2'h1,
      TRANS_NONSEQ = 2'h2,
      TRANS_SEQ = 2'h3
   } htrans_e;

   typedef enum {
      PHASE_IDLE,
      PHASE_WRITE,
      PHASE_READ
   } bus_phase_e;

endpackage

// >>> design/pin_edge_change_detect.sv
// edge-change interrupt detector for second-port pins 7..4 and third-port pins 7..0
// assumes an AHB-Lite master with single word transfers, pins asynchronous to ref_clk
`timescale 1ns/1ps
`include "pin_change_params.svh"

// Notes on behaviour
// - enabled rising edge sets second-port flag, summary
// - enabled falling edge sets second-port flag, summary
// - flags stay set until software writes zero
// - both enables zero means no detection
// - second-port low nibble ignores writes, reads zero
// - third-port rising enables set third-port flags
// - third-port bits six, seven only in full variant
// - all enables and flags reset to zero
// - summary flag is OR of all flags
// - master enable gates only the interrupt request
// - edge during clearing write leaves flag set
module pin_edge_change_detect
   import pin_change_pkg::*;
#(
   parameter bit FULL_VARIANT = 1'b1,
   parameter int PORTB_PINS = 4,
   parameter int PORTC_PINS = 8
) (
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire pin_change_pkg::ahb_req_s ahbReq,
   input wire logic [31:0] hwdata,
   output pin_change_pkg::ahb_resp_s ahbResp,
   input wire logic [7:0] secondPortPin,
   input wire logic [7:0] thirdPortPin,
   output logic summaryChangeFlag,
   output logic irqOut
);
   import pin_change_pkg::*;

   // --------------------------------------------------------------
   // elaboration checks
   // --------------------------------------------------------------
   if (PORTB_PINS != 4 || PORTC_PINS != 8) begin : g_bad_width
      $error("pin_edge_change_detect: only 4 second-port and 8 third-port pins");
   end

   localparam logic [7:0] PORTC_IMPL = FULL_VARIANT ? `PORTC_FULL_MASK : `PORTC_SMALL_MASK;
   localparam logic [7:0] PORTB_IMPL = `PORTB_IMPL_MASK;

   // --------------------------------------------------------------
   // registers
   // --------------------------------------------------------------
   logic [7:0] bRise_reg;
   logic [7:0] bFall_reg;
   logic [7:0] bFlag_reg;
   logic [7:0] bFlag_next;
   logic [7:0] cRise_reg;
   logic [7:0] cFlag_reg;
   logic [7:0] cFlag_next;
   logic masterEn_reg;
   logic [1:0] irqStat_reg;
   logic [1:0] irqStat_next;
   logic [1:0] irqMask_reg;
   logic summary_reg;
   logic irq_reg;
   logic [31:0] rdata_reg;

   // bus pipeline
   logic [11:0] addr_reg;
   bus_phase_e phase_reg;
   logic addrPhase;
   logic wrData;

   // edge detection
   logic [7:0] bRiseEdge;
   logic [7:0] bFallEdge;
   logic [7:0] cRiseEdge;
   logic [7:0] bHit;
   logic [7:0] cHit;
   logic [7:0] wrByte;

   // write strobes, one per register, all in the data phase
   logic wrBRise;
   logic wrBFall;
   logic wrBFlag;
   logic wrCRise;
   logic wrCFlag;
   logic wrCtl;
   logic wrStat;
   logic wrMask;
   logic [31:0] rdata_next;

   pin_edge_sync #(
      .WIDTH(8)
   ) u_sync_b (
      .ref_clk(ref_clk),
      .rst_n(rst_n),
      .pinIn(secondPortPin),
      .riseEdge(bRiseEdge),
      .fallEdge(bFallEdge)
   );

   pin_edge_sync #(
      .WIDTH(8)
   ) u_sync_c (
      .ref_clk(ref_clk),
      .rst_n(rst_n),
      .pinIn(thirdPortPin),
      .riseEdge(cRiseEdge),
      .fallEdge()
   );

   // --------------------------------------------------------------
   // edge qualification
   // --------------------------------------------------------------
   // zero enables give zero hits
   // one slice per pin; positions with no pin behind them stay tied to zero
   for (genvar k = 0; k < 8; k++) begin : g_pin
      logic bRiseHit;
      logic bFallHit;
      logic bKeep;
      logic cKeep;
      assign bRiseHit = bRiseEdge[k] & bRise_reg[k];
      assign bFallHit = bFallEdge[k] & bFall_reg[k];
      assign bHit[k] = PORTB_IMPL[k] & (bRiseHit | bFallHit);
      assign cHit[k] = PORTC_IMPL[k] & cRiseEdge[k] & cRise_reg[k];
      // writing zero clears, writing one leaves the flag as it was
      assign bKeep = bFlag_reg[k] & ~(wrBFlag & ~wrByte[k]);
      assign cKeep = cFlag_reg[k] & ~(wrCFlag & ~wrByte[k]);
      // a hit in the clearing cycle wins over the write
      assign bFlag_next[k] = PORTB_IMPL[k] & (bKeep | bHit[k]);
      assign cFlag_next[k] = PORTC_IMPL[k] & (cKeep | cHit[k]);
   end

   // --------------------------------------------------------------
   // AHB-Lite slave, zero wait states, always OKAY
   // --------------------------------------------------------------
   assign addrPhase = ahbReq.hsel && ahbReq.hready && (ahbReq.htrans == TRANS_NONSEQ
                      || ahbReq.htrans == TRANS_SEQ);
   assign wrData = (phase_reg == PHASE_WRITE);
   assign wrByte = hwdata[7:0];
   assign wrBRise = wrData && (addr_reg == `OFS_PORTB_RISE_ENABLE);
   assign wrBFall = wrData && (addr_reg == `OFS_PORTB_FALL_ENABLE);
   assign wrBFlag = wrData && (addr_reg == `OFS_PORTB_CHANGE_FLAGS);
   assign wrCRise = wrData && (addr_reg == `OFS_PORTC_RISE_ENABLE);
   assign wrCFlag = wrData && (addr_reg == `OFS_PORTC_CHANGE_FLAGS);
   assign wrCtl = wrData && (addr_reg == `OFS_CONTROL);
   assign wrStat = wrData && (addr_reg == `OFS_IRQ_STATUS);
   assign wrMask = wrData && (addr_reg == `OFS_IRQ_MASK);

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         phase_reg <= PHASE_IDLE;
         addr_reg <= 12'h000;
      end else begin
         if (addrPhase) begin
            phase_reg <= ahbReq.hwrite ? PHASE_WRITE : PHASE_READ;
            addr_reg <= ahbReq.haddr[11:0];
         end else begin
            phase_reg <= PHASE_IDLE;
         end
      end
   end

   // --------------------------------------------------------------
   // enable and control registers
   // --------------------------------------------------------------
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         bRise_reg <= `REG_RESET;
      end else if (wrBRise) begin
         bRise_reg <= wrByte & PORTB_IMPL;
      end
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         bFall_reg <= `REG_RESET;
      end else if (wrBFall) begin
         bFall_reg <= wrByte & PORTB_IMPL;
      end
   end

   // small variant keeps bits six and seven at zero
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         cRise_reg <= `REG_RESET;
      end else if (wrCRise) begin
         cRise_reg <= wrByte & PORTC_IMPL;
      end
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         masterEn_reg <= 1'b0;
      end else if (wrCtl) begin
         masterEn_reg <= hwdata[`CTRL_MASTER_EN_BIT];
      end
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         irqMask_reg <= 2'h0;
      end else if (wrMask) begin
         irqMask_reg <= hwdata[1:0] & `STAT_MASK;
      end
   end

   // --------------------------------------------------------------
   // change flags: software writes zero to clear, hardware set wins
   // --------------------------------------------------------------
   // next values come from the per-pin slices above
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         bFlag_reg <= `REG_RESET;
         cFlag_reg <= `REG_RESET;
      end else begin
         bFlag_reg <= bFlag_next;
         cFlag_reg <= cFlag_next;
      end
   end

   // --------------------------------------------------------------
   // per-port event status, write one to clear, set beats clear
   // --------------------------------------------------------------
   always_comb begin
      irqStat_next = irqStat_reg;
      if (wrStat) begin
         irqStat_next = irqStat_reg & ~hwdata[1:0];
      end
      irqStat_next[`STAT_PORTB_BIT] = irqStat_next[`STAT_PORTB_BIT] | (|bHit);
      irqStat_next[`STAT_PORTC_BIT] = irqStat_next[`STAT_PORTC_BIT] | (|cHit);
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         irqStat_reg <= 2'h0;
      end else begin
         irqStat_reg <= irqStat_next;
      end
   end

   // --------------------------------------------------------------
   // summary and interrupt outputs, registered from next values
   // --------------------------------------------------------------
   // registered from next state so the summary tracks flags in the same cycle
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         summary_reg <= 1'b0;
      end else begin
         summary_reg <= |{bFlag_next, cFlag_next};
      end
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         irq_reg <= 1'b0;
      end else begin
         // flags still set with master enable off raise nothing
         irq_reg <= masterEn_reg && ((|{bFlag_next, cFlag_next})
                    || (|(irqStat_next & irqMask_reg)));
      end
   end

   assign summaryChangeFlag = summary_reg;
   assign irqOut = irq_reg;

   // --------------------------------------------------------------
   // read data, captured at address phase so hrdata is a flop
   // --------------------------------------------------------------
   // flags are read from their next values so a set in the same cycle is not lost
   always_comb begin
      rdata_next = 32'h0000_0000;
      unique case (ahbReq.haddr[11:0])
         `OFS_PORTB_RISE_ENABLE: rdata_next = {24'h000000, bRise_reg};
         `OFS_PORTB_FALL_ENABLE: rdata_next = {24'h000000, bFall_reg};
         `OFS_PORTB_CHANGE_FLAGS: rdata_next = {24'h000000, bFlag_next};
         `OFS_PORTC_RISE_ENABLE: rdata_next = {24'h000000, cRise_reg};
         `OFS_PORTC_CHANGE_FLAGS: rdata_next = {24'h000000, cFlag_next};
         `OFS_CONTROL: rdata_next = {30'h00000000, summary_reg, masterEn_reg};
         `OFS_IRQ_STATUS: rdata_next = {30'h00000000, irqStat_next};
         `OFS_IRQ_MASK: rdata_next = {30'h00000000, irqMask_reg};
         default: rdata_next = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         rdata_reg <= 32'h0000_0000;
      end else if (addrPhase && !ahbReq.hwrite) begin
         rdata_reg <= rdata_next;
      end
   end

   assign ahbResp.hrdata = rdata_reg;
   assign ahbResp.hreadyout = 1'b1;
   assign ahbResp.hresp = 1'b0;

endmodule

// >>> design/pin_edge_sync.sv
// per-pin synchroniser and edge detector
// assumes pins are asynchronous to ref_clk
`timescale 1ns/1ps
`include "pin_change_params.svh"

module pin_edge_sync #(
   parameter int WIDTH = 8
) (
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic [WIDTH-1:0] pinIn,
   output logic [WIDTH-1:0] riseEdge,
   output logic [WIDTH-1:0] fallEdge
);

   logic [WIDTH-1:0] meta_reg;
   logic [WIDTH-1:0] sync_reg;
   logic [WIDTH-1:0] prev_reg;

   // --------------------------------------------------------------
   // two-flop sync then previous sample
   // --------------------------------------------------------------
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         meta_reg <= '0;
         sync_reg <= '0;
         prev_reg <= '0;
      end else begin
         meta_reg <= pinIn;
         sync_reg <= meta_reg;
         prev_reg <= sync_reg;
      end
   end

   // edges compare current with previous synchronised sample
   assign riseEdge = sync_reg & ~prev_reg;
   assign fallEdge = ~sync_reg & prev_reg;

endmodule
